// ---- core/pisr_cfg.svh ----
// Purpose: constants of the pack info readout block
// Assumes: SMBus slave on two pins, config image in a small memory
// Notes:   definitions only
`ifndef PISR_CFG_SVH
`define PISR_CFG_SVH

// Command codes
`define PISR_CMD_SPEC     8'h1a
`define PISR_CMD_DATE     8'h1b
`define PISR_CMD_SERIAL   8'h1c
`define PISR_CMD_MAKER    8'h20
`define PISR_CMD_MODEL    8'h21
`define PISR_CMD_CHEM     8'h22
`define PISR_CMD_VPARAM   8'h23
`define PISR_CMD_PACK     8'h2f
`define PISR_CMD_CELL_LO  8'h3c
`define PISR_CMD_CELL_HI  8'h3f

// Config image locations
`define PISR_NV_SPEC      7'h14
`define PISR_NV_DATE      7'h16
`define PISR_NV_SERIAL    7'h18
`define PISR_NV_MAKER     7'h20
`define PISR_NV_MODEL     7'h30
`define PISR_NV_PACKCFG   7'h3f
`define PISR_NV_CHEM      7'h40
`define PISR_NV_VPARAM    7'h50

// String limits and fixed block length
`define PISR_MAX_MAKER    4'hb
`define PISR_MAX_MODEL    4'h7
`define PISR_MAX_CHEM     4'h4
`define PISR_VPARAM_LEN   8'h07

// Pack configuration bit that arms the midrange correction
`define PISR_MIDFIX_BIT   1

// Error codes
`define PISR_ERR_OK       3'h0
`define PISR_ERR_UNSUP    3'h3
`define PISR_ERR_DENIED   3'h4

// Default slave address
`define PISR_SLAVE_ADDR   7'h0b

`endif

// ---- core/pisr_nv_mirror.sv ----
// Purpose: mirror of the configuration image
// Assumes: loader writes one byte a cycle
// Notes:   read data registered, one cycle latency
`timescale 1ns/1ps
module pisr_nv_mirror #(
   parameter int AW = 7,                     // Address width
   parameter int DW = 8                      // Data width
) (
   input  wire logic          mclk,          // System clock
   input  wire logic          wr_en,         // Write strobe
   input  wire logic [AW-1:0] wr_addr,       // Write address
   input  wire logic [DW-1:0] wr_data,       // Write data
   input  wire logic [AW-1:0] rd_addr,       // Read address
   output logic      [DW-1:0] rd_data        // Registered read data
);
   logic [DW-1:0] mem [2**AW];

   // No reset on the array so it can map to plain RAM
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : pisr_nv_mirror

// ---- core/pisr_pkg.sv ----
// Purpose: types of the pack info readout block
// Assumes: constants come from pisr_cfg.svh
// Notes:   state of the top is one packed struct
package pisr_pkg;

   // Bus engine states
   typedef enum logic [2:0] {
      PISR_IDLE = 3'b000,
      PISR_ADDR = 3'b001,
      PISR_CMD  = 3'b010,
      PISR_WDAT = 3'b011,
      PISR_ACK  = 3'b100,
      PISR_TX   = 3'b101,
      PISR_HACK = 3'b110
   } pisr_state_e;

   // Live measurement and protection inputs
   typedef struct packed {
      logic        cal_en;       // Offset calibration enabled
      logic        cal_done;     // Offset calibration finished
      logic        coulomb;      // Converter pulse activity
      logic        learn_ok;     // Discharge cycle qualifies
      logic        safety_exc;   // Safety output limits exceeded
      logic        over;         // Over protect condition
      logic        under;        // Under protect condition
      logic        use_cell;     // Monitor cell instead of pack
      logic        midfix_done;  // Midrange correction attempted
      logic [15:0] pack_mv;      // Pack voltage
      logic [15:0] cell_min_mv;  // Lowest cell voltage
      logic [15:0] low_voltage_warn_mv;      // Second discharge threshold
      logic [15:0] edv_pend_mv;  // Pending discharge threshold
   } pisr_meas_s;

   // Whole state of the top module
   typedef struct packed {
      logic [2:0]  scl_s;        // Clock pin synchroniser
      logic [2:0]  sda_s;        // Data pin synchroniser
      logic        scl_f;        // Filtered clock level
      logic        sda_f;        // Filtered data level
      pisr_state_e st;           // Engine state
      pisr_state_e nst;          // State after acknowledge
      logic [3:0]  cnt;          // Bit counter
      logic [7:0]  sreg;         // Shift register
      logic [7:0]  cmd;          // Latched command
      logic        cmd_ok;       // Command valid for a read
      logic [3:0]  bidx;         // Byte index of reply
      logic        hnack;        // Host refused last byte
      logic        drive;        // Pull data low
      logic [2:0]  err;          // Last error code
      logic [7:0]  pack_cfg;     // Pack configuration mirror
      logic        ocal;         // Offset cancel on
      logic        safety_limit_tripped;          // Safety limit tripped
   } pisr_st_s;

endpackage : pisr_pkg

// ---- core/pisr_top.sv ----
// Purpose: SMBus readout of pack identity, status and cell voltages
// Assumes: configuration image loaded through the nv write port
// Notes:   slave never stretches the clock; data pin is open drain
`timescale 1ns/1ps
`include "pisr_cfg.svh"
module pisr_top
   import pisr_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = `PISR_SLAVE_ADDR  // Bus address
) (
   input  wire logic             mclk,        // 125 MHz clock
   input  wire logic             resetn,      // Async reset, low
   input  wire logic             smb_clk_in,  // Bus clock pin
   input  wire logic             smb_dat_in,  // Bus data pin level
   output logic                  smb_dat_out, // Data out, always low
   output logic                  smb_dat_oe,  // Data pull enable
   input  wire logic             nv_wr,       // Image byte write
   input  wire logic [6:0]       nv_waddr,    // Image byte address
   input  wire logic [7:0]       nv_wdata,    // Image byte data
   input  wire pisr_meas_s       meas,        // Live measurements
   input  wire logic [3:0][15:0] cell_mv,     // Cell voltages 1..4
   output logic      [7:0]       pack_status, // Status byte
   output logic      [7:0]       pack_cfg,    // Configuration byte
   output logic      [2:0]       err_code     // Last error code
);
   pisr_st_s   s;
   pisr_st_s   n;
   logic [6:0] nv_raddr;
   logic [7:0] nv_rdata;
   logic [7:0] stat_byte;
   logic [7:0] tx_byte;
   logic [15:0] mon_mv;
   logic       scl_new;
   logic       sda_new;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_c;
   logic       stop_c;
   logic       tx_load;

   // Codes this block answers
   function automatic logic is_ro_cmd(input logic [7:0] c);
      return (c == `PISR_CMD_SPEC) || (c == `PISR_CMD_DATE) ||
             (c == `PISR_CMD_SERIAL) || (c == `PISR_CMD_MAKER) ||
             (c == `PISR_CMD_MODEL) || (c == `PISR_CMD_CHEM) ||
             (c == `PISR_CMD_VPARAM) || (c == `PISR_CMD_PACK) ||
             ((c >= `PISR_CMD_CELL_LO) && (c <= `PISR_CMD_CELL_HI));
   endfunction : is_ro_cmd

   // Base location of a command's bytes in the image
   function automatic logic [6:0] nv_base(input logic [7:0] c);
      case (c)
         `PISR_CMD_SPEC:   return `PISR_NV_SPEC;
         `PISR_CMD_DATE:   return `PISR_NV_DATE;
         `PISR_CMD_SERIAL: return `PISR_NV_SERIAL;
         `PISR_CMD_MAKER:  return `PISR_NV_MAKER;
         `PISR_CMD_MODEL:  return `PISR_NV_MODEL;
         `PISR_CMD_CHEM:   return `PISR_NV_CHEM;
         default:          return `PISR_NV_VPARAM;
      endcase
   endfunction : nv_base

   // String limit of a block command
   function automatic logic [3:0] blk_max(input logic [7:0] c);
      case (c)
         `PISR_CMD_MAKER: return `PISR_MAX_MAKER;
         `PISR_CMD_MODEL: return `PISR_MAX_MODEL;
         default:         return `PISR_MAX_CHEM;
      endcase
   endfunction : blk_max

   pisr_nv_mirror #(
      .AW (7),
      .DW (8)
   ) u_nv (
      .mclk    (mclk),
      .wr_en   (nv_wr),
      .wr_addr (nv_waddr),
      .wr_data (nv_wdata),
      .rd_addr (nv_raddr),
      .rd_data (nv_rdata)
   );

   // Reply byte address; settles during the acknowledge bit
   assign nv_raddr = nv_base(s.cmd) + {3'h0, s.bidx};

   // Monitored voltage picked by the program option
   assign mon_mv = meas.use_cell ? meas.cell_min_mv : meas.pack_mv;

   // Status byte, bit 3 unused
   assign stat_byte = {s.ocal,
                       (mon_mv <= meas.low_voltage_warn_mv),
                       meas.coulomb,
                       meas.learn_ok,
                       1'b0,
                       s.safety_limit_tripped,
                       meas.over,
                       meas.under};

   // Byte to send for the current command and index
   always_comb begin
      tx_byte = 8'hff;
      case (s.cmd)
         `PISR_CMD_SPEC, `PISR_CMD_DATE, `PISR_CMD_SERIAL: begin
            // Word images stored low byte at the lower location
            if (s.bidx < 4'h2) begin
               tx_byte = nv_rdata;
            end
         end
         `PISR_CMD_MAKER, `PISR_CMD_MODEL, `PISR_CMD_CHEM: begin
            // Clamp a bad length so the host never over-reads
            if (s.bidx == 4'h0) begin
               tx_byte = (nv_rdata > {4'h0, blk_max(s.cmd)}) ?
                         {4'h0, blk_max(s.cmd)} : nv_rdata;
            end else if (s.bidx <= blk_max(s.cmd)) begin
               tx_byte = nv_rdata;
            end
         end
         `PISR_CMD_VPARAM: begin
            case (s.bidx)
               4'h0:    tx_byte = `PISR_VPARAM_LEN;
               4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
                        tx_byte = nv_rdata;
               4'h6:    tx_byte = meas.edv_pend_mv[7:0];
               4'h7:    tx_byte = meas.edv_pend_mv[15:8];
               default: tx_byte = 8'hff;
            endcase
         end
         `PISR_CMD_PACK: begin
            if (s.bidx == 4'h0) begin
               tx_byte = stat_byte;
            end else if (s.bidx == 4'h1) begin
               tx_byte = s.pack_cfg;
            end
         end
         default: begin
            // Cell commands: 0x3c is the fourth cell
            if (s.bidx == 4'h0) begin
               tx_byte = cell_mv[2'd3 - s.cmd[1:0]][7:0];
            end else if (s.bidx == 4'h1) begin
               tx_byte = cell_mv[2'd3 - s.cmd[1:0]][15:8];
            end
         end
      endcase
   end

   // Filtered pin levels: a change counts once stages 2 and 3 agree
   assign scl_new  = (s.scl_s[1] == s.scl_s[2]) ? s.scl_s[2] : s.scl_f;
   assign sda_new  = (s.sda_s[1] == s.sda_s[2]) ? s.sda_s[2] : s.sda_f;
   assign scl_rise = scl_new & ~s.scl_f;
   assign scl_fall = ~scl_new & s.scl_f;
   assign start_c  = s.scl_f & scl_new & s.sda_f & ~sda_new;
   assign stop_c   = s.scl_f & scl_new & ~s.sda_f & sda_new;
   assign tx_load  = scl_fall & ~start_c & ~stop_c &
                     (((s.st == PISR_ACK) && (s.nst == PISR_TX)) ||
                      ((s.st == PISR_HACK) && !s.hnack));

   // Next state of the whole block
   always_comb begin
      n       = s;
      n.scl_s = {s.scl_s[1:0], smb_clk_in};
      n.sda_s = {s.sda_s[1:0], smb_dat_in};
      n.scl_f = scl_new;
      n.sda_f = sda_new;

      // Offset cancel: set on completion, zero while disabled
      if (!meas.cal_en) begin
         n.ocal = 1'b0;
      end else if (meas.cal_done) begin
         n.ocal = 1'b1;
      end
      // Safety trip holds until reset
      if (meas.safety_exc) begin
         n.safety_limit_tripped = 1'b1;
      end
      // Loader write wins so a reload rearms the correction
      if (nv_wr && (nv_waddr == `PISR_NV_PACKCFG)) begin
         n.pack_cfg = nv_wdata;
      end else if (meas.midfix_done) begin
         n.pack_cfg[`PISR_MIDFIX_BIT] = 1'b0;
      end

      if (stop_c) begin
         n.st     = PISR_IDLE;
         n.drive  = 1'b0;
         n.cmd_ok = 1'b0;
      end else if (start_c) begin
         n.st    = PISR_ADDR;
         n.cnt   = 4'h0;
         n.bidx  = 4'h0;
         n.drive = 1'b0;
      end else begin
         case (s.st)
            PISR_ADDR, PISR_CMD, PISR_WDAT: begin
               if (scl_rise) begin
                  n.sreg = {s.sreg[6:0], sda_new};
                  n.cnt  = s.cnt + 4'h1;
               end else if (scl_fall && (s.cnt == 4'h8)) begin
                  n.st  = PISR_ACK;
                  n.nst = PISR_IDLE;
                  if (s.st == PISR_ADDR) begin
                     if (s.sreg[7:1] == SLAVE_ADDR) begin
                        // Reads only after a valid command
                        if (!s.sreg[0]) begin
                           n.drive = 1'b1;
                           n.nst   = PISR_CMD;
                        end else if (s.cmd_ok) begin
                           n.drive = 1'b1;
                           n.nst   = PISR_TX;
                        end
                     end
                  end else if (s.st == PISR_CMD) begin
                     n.cmd    = s.sreg;
                     n.cmd_ok = is_ro_cmd(s.sreg);
                     n.drive  = is_ro_cmd(s.sreg);
                     n.err    = is_ro_cmd(s.sreg) ? `PISR_ERR_OK :
                                                    `PISR_ERR_UNSUP;
                     n.nst    = is_ro_cmd(s.sreg) ? PISR_WDAT :
                                                    PISR_IDLE;
                  end else begin
                     // Data byte of a write: refuse it
                     n.err    = `PISR_ERR_DENIED;
                     n.cmd_ok = 1'b0;
                  end
               end
            end
            PISR_ACK: begin
               if (scl_fall) begin
                  n.cnt = 4'h0;
                  n.st  = s.nst;
                  if (s.nst == PISR_TX) begin
                     n.sreg  = tx_byte;
                     n.drive = ~tx_byte[7];
                  end else begin
                     n.drive = 1'b0;
                  end
               end
            end
            PISR_TX: begin
               // Most significant bit first within each byte
               if (scl_fall) begin
                  if (s.cnt == 4'h7) begin
                     n.drive = 1'b0;
                     n.st    = PISR_HACK;
                     n.bidx  = s.bidx + 4'h1;
                  end else begin
                     n.sreg  = {s.sreg[6:0], 1'b0};
                     n.drive = ~s.sreg[6];
                     n.cnt   = s.cnt + 4'h1;
                  end
               end
            end
            PISR_HACK: begin
               if (scl_rise) begin
                  n.hnack = sda_new;
               end else if (scl_fall) begin
                  if (s.hnack) begin
                     n.st = PISR_IDLE;
                  end else begin
                     n.st    = PISR_TX;
                     n.cnt   = 4'h0;
                     n.sreg  = tx_byte;
                     n.drive = ~tx_byte[7];
                  end
               end
            end
            default: begin
               n.drive = 1'b0;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Outputs
   assign smb_dat_out = 1'b0;
   assign smb_dat_oe  = s.drive;
   assign pack_status = stat_byte;
   assign pack_cfg    = s.pack_cfg;
   assign err_code    = s.err;

   // Checks
   property p_sov_hold;
      @(posedge mclk) disable iff (!resetn)
      s.safety_limit_tripped |=> s.safety_limit_tripped [*8];
   endproperty
   a_sov_hold: assert property (p_sov_hold)
      else $error("safety trip bit dropped");

   property p_sov_set;
      @(posedge mclk) disable iff (!resetn)
      meas.safety_exc |=> pack_status[2];
   endproperty
   a_sov_set: assert property (p_sov_set)
      else $error("safety trip not reported");

   property p_ocal_off;
      @(posedge mclk) disable iff (!resetn)
      !meas.cal_en |=> !pack_status[7];
   endproperty
   a_ocal_off: assert property (p_ocal_off)
      else $error("offset cancel set while disabled");

   property p_lvw;
      @(posedge mclk) disable iff (!resetn)
      pack_status[6] == (meas.use_cell ? (meas.cell_min_mv <= meas.low_voltage_warn_mv)
                                       : (meas.pack_mv <= meas.low_voltage_warn_mv));
   endproperty
   a_lvw: assert property (p_lvw)
      else $error("low voltage warning wrong");

   property p_prot;
      @(posedge mclk) disable iff (!resetn)
      pack_status[1:0] == {meas.over, meas.under} && !pack_status[3];
   endproperty
   a_prot: assert property (p_prot)
      else $error("protect bits do not follow inputs");

   property p_midfix;
      @(posedge mclk) disable iff (!resetn)
      meas.midfix_done && !nv_wr |=> !pack_cfg[`PISR_MIDFIX_BIT];
   endproperty
   a_midfix: assert property (p_midfix)
      else $error("midrange fix bit not cleared");

   property p_wr_deny;
      @(posedge mclk) disable iff (!resetn)
      (s.st == PISR_WDAT) && scl_fall && (s.cnt == 4'h8) &&
      !start_c && !stop_c
      |=> (err_code == `PISR_ERR_DENIED) && !smb_dat_oe;
   endproperty
   a_wr_deny: assert property (p_wr_deny)
      else $error("write to read-only code not refused");

   property p_status_lsb;
      @(posedge mclk) disable iff (!resetn)
      tx_load && (s.cmd == `PISR_CMD_PACK) && (s.bidx == 4'h0)
      |=> s.sreg == $past(stat_byte);
   endproperty
   a_status_lsb: assert property (p_status_lsb)
      else $error("status byte not sent first");

   property p_cell;
      @(posedge mclk) disable iff (!resetn)
      tx_load && (s.cmd == `PISR_CMD_CELL_LO) && (s.bidx == 4'h1)
      |=> s.sreg == $past(cell_mv[3][15:8]);
   endproperty
   a_cell: assert property (p_cell)
      else $error("cell voltage high byte wrong");

   c_read_done: cover property (@(posedge mclk) disable iff (!resetn)
      (s.st == PISR_HACK) && scl_fall && s.hnack);
   c_denied: cover property (@(posedge mclk) disable iff (!resetn)
      err_code == `PISR_ERR_DENIED);
   c_block: cover property (@(posedge mclk) disable iff (!resetn)
      tx_load && (s.cmd == `PISR_CMD_MAKER) && (s.bidx == 4'h3));
endmodule : pisr_top

// ---- sim/pisr_host_model.sv ----
// Purpose: SMBus host model that reads the pack readout slave
// Assumes: open drain data line with pull-up, host owns the clock
// Notes:   bench calls the tasks through the instance
`timescale 1ns/1ps
module pisr_host_model #(
   parameter logic [6:0] A = 7'h0b,   // Slave address
   parameter int         Q = 6        // Quarter bit in mclk cycles
) (
   input  wire logic mclk,            // System clock
   input  wire logic sda,             // Resolved data line
   output logic      scl,             // Bus clock
   output logic      sda_low          // Host pulls data low
);
   // Idle bus with both lines released
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   task automatic qw(input int n);
      repeat (n * Q) @(posedge mclk);
   endtask : qw

   // Data moves a quarter after the fall, never near the edge, so
   // the slave cannot mistake it for a start or stop
   task automatic bit_x(input logic b, output logic r);
      qw(1);
      sda_low <= !b;
      qw(1);
      scl <= 1'b1;
      qw(1);
      r = sda;
      qw(1);
      scl <= 1'b0;
   endtask : bit_x

   task automatic start_c;
      qw(1);
      sda_low <= 1'b0;
      qw(1);
      scl <= 1'b1;
      qw(1);
      sda_low <= 1'b1;
      qw(1);
      scl <= 1'b0;
   endtask : start_c

   task automatic stop_c;
      qw(1);
      sda_low <= 1'b1;
      qw(1);
      scl <= 1'b1;
      qw(1);
      sda_low <= 1'b0;
      qw(2);
   endtask : stop_c

   // Eight bits MSB first then the ack bit; send ff to read
   task automatic byte_x(input logic [7:0] w, input logic last,
                         output logic [7:0] r, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_x(w[i], b);
         r[i] = b;
      end
      bit_x(last, b);
      ack = !b;
   endtask : byte_x

   // Read Word or Read Block, host refuses the last byte
   task automatic rd(input logic [7:0] cmd, input int n,
                     output logic [7:0] d [16], output logic ok);
      logic [7:0] x;
      logic       a;
      start_c();
      byte_x({A, 1'b0}, 1'b1, x, ok);
      byte_x(cmd, 1'b1, x, a);
      ok = ok & a;
      start_c();
      byte_x({A, 1'b1}, 1'b1, x, a);
      ok = ok & a;
      for (int i = 0; i < n; i++)
         byte_x(8'hff, i == n - 1, d[i], a);
      stop_c();
   endtask : rd

   // Write of one data byte; ok tells whether the data was acked
   task automatic wr(input logic [7:0] cmd, input logic [7:0] v,
                     output logic ok);
      logic [7:0] x;
      logic       a;
      start_c();
      byte_x({A, 1'b0}, 1'b1, x, a);
      byte_x(cmd, 1'b1, x, a);
      byte_x(v, 1'b1, x, ok);
      stop_c();
   endtask : wr
endmodule : pisr_host_model

// ---- sim/pisr_top_tb.sv ----
// Purpose: self-checking bench of the pack readout block
// Assumes: image loaded before any read
// Notes:   expectations come from the bench's own image copy
`timescale 1ns/1ps
`include "pisr_cfg.svh"
module pisr_top_tb;
   import pisr_pkg::*;
   logic             mclk;
   logic             resetn;
   logic             nv_wr;
   logic [6:0]       nv_waddr;
   logic [7:0]       nv_wdata;
   pisr_meas_s       meas;
   logic [3:0][15:0] cell_mv;
   logic [7:0]       pack_status;
   logic [7:0]       pack_cfg;
   logic [2:0]       err_code;
   logic             scl;
   logic             sda_low;
   logic             dat_oe;
   logic             dat_out;
   logic [7:0]       img [128];
   logic [7:0]       d [16];
   logic             ok;
   int               error_cnt;
   int               n_checks;
   int               cyc;
   wire              sda;

   // Open drain line with pull-up
   assign sda = !(sda_low | (dat_oe & !dat_out));

   pisr_top u_dut (.mclk(mclk), .resetn(resetn), .smb_clk_in(scl),
      .smb_dat_in(sda), .smb_dat_out(dat_out), .smb_dat_oe(dat_oe),
      .nv_wr(nv_wr), .nv_waddr(nv_waddr), .nv_wdata(nv_wdata),
      .meas(meas), .cell_mv(cell_mv), .pack_status(pack_status),
      .pack_cfg(pack_cfg), .err_code(err_code));
   pisr_host_model #(.A(`PISR_SLAVE_ADDR)) u_host (.mclk(mclk),
      .sda(sda), .scl(scl), .sda_low(sda_low));

   task automatic chk(input string what, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   task automatic t_load;
      for (int a = 0; a < 96; a++) begin
         img[a] = 8'(a) ^ 8'h5a;
         if (a == 'h30) img[a] = 8'h06;
         if (a == 'h3f) img[a] = 8'he2;
         nv_wr    <= 1'b1;
         nv_waddr <= 7'(a);
         nv_wdata <= img[a];
         @(posedge mclk);
         nv_wr <= 1'b0;
         @(posedge mclk);
      end
   endtask : t_load

   task automatic t_words;
      logic [6:0]  b;
      logic [15:0] w;
      for (int i = 0; i < 3; i++) begin
         b = 7'h14 + 7'(2 * i);
         w = {img[b + 1], img[b]};
         u_host.rd(8'h1a + 8'(i), 2, d, ok);
         chk("ack", ok, 1'b1);
         chk("word", {d[1], d[0]}, w);
      end
   endtask : t_words

   // Maker and chemistry lengths clamp, model length fits
   task automatic t_blocks;
      logic [6:0] b;
      logic [7:0] mx;
      logic [7:0] n;
      for (int i = 0; i < 3; i++) begin
         b  = 7'h20 + 7'(16 * i);
         mx = (i == 0) ? 8'h0b : (i == 1) ? 8'h07 : 8'h04;
         n  = (img[b] > mx) ? mx : img[b];
         u_host.rd(8'h20 + 8'(i), int'(n) + 1, d, ok);
         chk("blk_len", d[0], n);
         for (int k = 0; k < int'(n); k++)
            chk("blk_chr", d[k + 1], img[b + 7'(k) + 1]);
      end
   endtask : t_blocks

   task automatic t_vparam;
      meas.edv_pend_mv <= 16'hbeef;
      u_host.rd(8'h23, 8, d, ok);
      chk("vp_len", d[0], 8'h07);
      for (int k = 0; k < 5; k++)
         chk("vp_byte", d[k + 1], img[7'h51 + 7'(k)]);
      chk("vp_edv", {d[7], d[6]}, 16'hbeef);
   endtask : t_vparam

   task automatic t_status;
      // Calibrated, pack exactly at threshold, over protect on
      meas.cal_en   <= 1'b1;
      meas.cal_done <= 1'b1;
      meas.coulomb  <= 1'b1;
      meas.over     <= 1'b1;
      meas.low_voltage_warn_mv  <= 16'h0d00;
      meas.pack_mv  <= 16'h0d00;
      u_host.rd(8'h2f, 2, d, ok);
      chk("status_a", {d[1], d[0]}, 16'he2e2);
      // Cell just above threshold while pack is below it
      meas.cal_en      <= 1'b0;
      meas.coulomb     <= 1'b0;
      meas.over        <= 1'b0;
      meas.learn_ok    <= 1'b1;
      meas.under       <= 1'b1;
      meas.use_cell    <= 1'b1;
      meas.cell_min_mv <= 16'h0d01;
      meas.pack_mv     <= 16'h0c00;
      meas.safety_exc  <= 1'b1;
      meas.midfix_done <= 1'b1;
      @(posedge mclk);
      meas.safety_exc  <= 1'b0;
      meas.midfix_done <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("status_b", pack_status, 8'h15);
      u_host.rd(8'h2f, 2, d, ok);
      chk("status_c", {d[1], d[0]}, 16'he015);
   endtask : t_status

   task automatic t_cells;
      for (int i = 0; i < 4; i++)
         cell_mv[i] <= 16'h0c80 + 16'(i);
      for (int i = 0; i < 4; i++) begin
         u_host.rd(8'h3c + 8'(i), 2, d, ok);
         chk("cell", {d[1], d[0]}, 16'h0c80 + 16'(3 - i));
      end
   endtask : t_cells

   // Write to a read-only code, then an unknown code
   task automatic t_deny;
      u_host.wr(8'h1c, 8'h55, ok);
      chk("wr_ack", ok, 1'b0);
      chk("wr_err", err_code, `PISR_ERR_DENIED);
      u_host.rd(8'h1d, 2, d, ok);
      chk("bad_ack", ok, 1'b0);
      chk("bad_err", err_code, `PISR_ERR_UNSUP);
   endtask : t_deny

   // Mid-run reset is the only way out of a safety trip
   task automatic t_reset;
      chk("sov_held", pack_status[2], 1'b1);
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("sov_rst", pack_status[2], 1'b0);
      chk("cfg_rst2", pack_cfg, 8'h00);
      u_host.rd(8'h1c, 2, d, ok);
      chk("rst_word", {d[1], d[0]}, {img[7'h19], img[7'h18]});
   endtask : t_reset

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Hang guard, a full run needs well under half of this
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 90000) begin
         error_cnt++;
         give_verdict();
      end
   end

   initial begin
      resetn   = 1'b0;
      nv_wr    = 1'b0;
      nv_waddr = 7'h00;
      nv_wdata = 8'h00;
      meas     = '0;
      cell_mv  = '0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("cfg_rst", pack_cfg, 8'h00);
      chk("err_rst", err_code, `PISR_ERR_OK);
      t_load();
      t_words();
      t_blocks();
      t_vparam();
      t_status();
      t_cells();
      t_deny();
      t_reset();
      give_verdict();
   end
endmodule : pisr_top_tb
